// >>> eeelpc_pkg.sv
// constants and types shared by the low-power-idle control block
// Operation
// - raise tx request after programmed empty delay
// - fifo data restarts the empty timer
// - withdraw request when fifo becomes non-empty
// - empty timer cleared while energy saving off
// - request only when enabled, 100FD, both capable
// - link up one second before requesting
// - request regardless of mac transmit enable
// - lpi to phy: txen 0, txer 1, 0001
// - finish current frame before signalling lpi
// - wake wait plus ipg before next frame
// - count tx lpi rising transitions, read only
// - count tx lpi microseconds, excluding wake wait
// - all four counters zero while disabled
// - decode rx lpi only under same conditions
// - decode rx lpi regardless of receive enable
// - count rx lpi rising transitions, read only
// - count rx lpi microseconds, read only
package eeelpc_pkg;
   // core clock and derived timebase
   localparam int CLK_PERIOD_NS   = 10;
   localparam int US_NS           = 1000;
   localparam int CYCLES_PER_US   = US_NS / CLK_PERIOD_NS;
   localparam int TICK_W          = 7;
   // inter-packet gap: 96 bit times at 100 Mbps, 10 ns per bit
   localparam int IPG_BITS        = 96;
   localparam int BIT_NS          = 10;
   localparam int IPG_NS          = IPG_BITS * BIT_NS;
   localparam int IPG_CYCLES      = (IPG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IPG_W           = 8;
   // link stability time, one second in microseconds
   localparam int LINK_STABLE_US  = 1000000;
   localparam int LINK_W          = 20;
   // field widths
   localparam int DELAY_W         = 16;
   localparam int CNT_W           = 32;
   localparam int TIMER_W         = 16;
   localparam int NIB_W           = 4;
   // lpi code on the nibble, both directions
   localparam logic [3:0] LPI_CODE = 4'h1;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_EMPTY,
      TX_LPI,
      TX_DRAIN,
      TX_TWAIT,
      TX_IPG
   } eeelpc_tx_state_t;
endpackage

// >>> eeelpc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module eeelpc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,    // destination clock
   input  wire logic [W-1:0] d,      // level from the other domain
   output logic      [W-1:0] q       // synchronised level
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule

// >>> eeelpc_lpi_cnt.sv
// transition and microsecond time counters for one lpi direction
`timescale 1ns/100ps
module eeelpc_lpi_cnt
   import eeelpc_pkg::*;
(
   input  wire logic             clk,          // core clock
   input  wire logic             rst,          // synchronous reset
   input  wire logic             enable,       // energy saving enabled
   input  wire logic             active,       // lpi level, core domain
   input  wire logic             us_tick,      // one-cycle microsecond pulse
   output logic      [CNT_W-1:0] trans_cnt_q,  // rising transitions
   output logic      [CNT_W-1:0] time_cnt_q    // microseconds active
);
   logic prev_q;
   wire  rise_w = active && !prev_q;

   // counters wrap; no clear on read since there is no read path at all
   always_ff @(posedge clk)
   begin
      if (rst || !enable)
      begin
         prev_q      <= 1'b0;
         trans_cnt_q <= '0;
         time_cnt_q  <= '0;
      end
      else
      begin
         prev_q <= active;
         if (rise_w)
            trans_cnt_q <= trans_cnt_q + 1'b1;
         if (active && us_tick)
            time_cnt_q <= time_cnt_q + 1'b1;
      end
   end
endmodule

// >>> eeelpc_top.sv
// low-power-idle control for one 100 Mbps full duplex mac port
`timescale 1ns/100ps
module eeelpc_top
   import eeelpc_pkg::*;
#(
   parameter int unsigned LINK_STABLE = LINK_STABLE_US
) (
   input  wire logic               ref_clk,               // core clock, 100 MHz
   input  wire logic               sys_rst,               // synchronous reset, active high
   input  wire logic               phy_clk,               // mii clock from the phy
   input  wire logic               energy_saving_enable,  // master enable
   input  wire logic               speed_100,             // link speed is 100 Mbps
   input  wire logic               full_duplex,           // link is full duplex
   input  wire logic               eee_local_adv,         // local end advertises lpi at 100
   input  wire logic               eee_partner_adv,       // partner advertises lpi at 100
   input  wire logic               phy_link_up,           // phy link status pin, async
   input  wire logic               tx_fifo_empty,         // transmit fifo empty
   input  wire logic               tx_frame_active,       // mac core is sending a frame
   input  wire logic [DELAY_W-1:0] tx_lpi_request_delay,  // empty time before request, us
   input  wire logic [DELAY_W-1:0] tx_wake_wait_time,     // wake wait after lpi, us
   input  wire logic               mac_txen,              // mac transmit enable, phy_clk
   input  wire logic               mac_txer,              // mac transmit error, phy_clk
   input  wire logic [NIB_W-1:0]   mac_txd,               // mac transmit nibble, phy_clk
   input  wire logic               mii_rxdv,              // phy receive data valid
   input  wire logic               mii_rxer,              // phy receive error
   input  wire logic [NIB_W-1:0]   mii_rxd,               // phy receive nibble
   output logic                    mii_txen,              // to phy, transmit enable
   output logic                    mii_txer,              // to phy, transmit error
   output logic      [NIB_W-1:0]   mii_txd,               // to phy, transmit nibble
   output logic                    tx_lpi_request,        // internal client lpi request
   output logic                    tx_hold_off,           // mac must not start a frame
   output logic                    rx_lpi_active,         // decoded receive lpi
   output logic                    link_stable,           // link up for one second
   output logic      [CNT_W-1:0]   tx_lpi_transitions,    // tx lpi transition count
   output logic      [CNT_W-1:0]   tx_lpi_time_us,        // tx lpi time, us
   output logic      [CNT_W-1:0]   rx_lpi_transitions,    // rx lpi transition count
   output logic      [CNT_W-1:0]   rx_lpi_time_us         // rx lpi time, us
);

   // ---------------- core domain declarations
   logic [TICK_W-1:0]  tick_cnt_q;
   logic [TICK_W-1:0]  tick_cnt_d;
   logic               us_tick_q;
   logic [LINK_W-1:0]  link_cnt_q;
   logic [LINK_W-1:0]  link_cnt_d;
   logic               link_stable_q;
   logic               link_up_s;
   eeelpc_tx_state_t   state_q;
   eeelpc_tx_state_t   state_d;
   logic [TIMER_W-1:0] timer_q;
   logic [TIMER_W-1:0] timer_d;
   logic [IPG_W-1:0]   ipg_q;
   logic [IPG_W-1:0]   ipg_d;
   logic               req_q;
   logic               req_d;
   logic               hold_q;
   logic               hold_d;
   // set while the first, partial microsecond of a timed span is still running
   logic               part_q;
   logic               part_d;
   logic               phy_lpi_s;
   logic               rx_lpi_s;
   logic               rx_active_q;

   // ---------------- link domain declarations
   logic               link_rst;
   logic               req_s;
   logic               phy_lpi_q;
   logic               txen_q;
   logic               txer_q;
   logic [NIB_W-1:0]   txd_q;
   logic               rx_code_q;

   // counts a timer up by one, saturating at all ones
   function automatic logic [TIMER_W-1:0] sat_inc(input logic [TIMER_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   // ---------------- microsecond timebase
   // free running; the first interval after a start may be short by up to one us
   wire tick_wrap_w = (tick_cnt_q == TICK_W'(CYCLES_PER_US - 1));
   assign tick_cnt_d = tick_wrap_w ? '0 : tick_cnt_q + 1'b1;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         tick_cnt_q <= '0;
         us_tick_q  <= 1'b0;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_d;
         us_tick_q  <= tick_wrap_w;
      end
   end

   // ---------------- link stability
   // the status pin is asynchronous, so it is synchronised before use
   eeelpc_sync #(
      .W (1)
   ) u_link_sync (
      .clk (ref_clk),
      .d   (phy_link_up),
      .q   (link_up_s)
   );

   // any drop of the link restarts the one second wait
   wire link_done_w = (link_cnt_q >= LINK_W'(LINK_STABLE));
   assign link_cnt_d = !link_up_s ? '0 :
                       (us_tick_q && !link_done_w) ? link_cnt_q + 1'b1 : link_cnt_q;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         link_cnt_q    <= '0;
         link_stable_q <= 1'b0;
      end
      else
      begin
         link_cnt_q    <= link_cnt_d;
         link_stable_q <= link_up_s && link_done_w;
      end
   end

   // ---------------- allowance
   // the mac transmit and receive enable bits are deliberately not inputs
   wire capable_w = speed_100 && full_duplex && eee_local_adv && eee_partner_adv;
   wire allow_w   = energy_saving_enable && capable_w && link_stable_q;

   // ---------------- transmit request state machine
   wire fifo_idle_w  = tx_fifo_empty && !tx_frame_active;
   wire delay_met_w  = (timer_q >= TIMER_W'(tx_lpi_request_delay));
   wire wake_met_w   = (timer_q >= TIMER_W'(tx_wake_wait_time));
   wire ipg_met_w    = (ipg_q >= IPG_W'(IPG_CYCLES - 1));

   always_comb
   begin
      state_d = state_q;
      timer_d = timer_q;
      ipg_d   = ipg_q;
      req_d   = 1'b0;
      hold_d  = hold_q;
      part_d  = part_q;
      case (state_q)
         TX_IDLE:
         begin
            timer_d = '0;
            part_d  = 1'b1;
            hold_d  = 1'b0;
            if (allow_w && fifo_idle_w)
               state_d = TX_EMPTY;
         end
         TX_EMPTY:
         begin
            if (!allow_w)
            begin
               state_d = TX_IDLE;
               timer_d = '0;
            end
            else if (!fifo_idle_w)
            begin
               timer_d = '0;
               part_d  = 1'b1;
            end
            else if (delay_met_w)
            begin
               state_d = TX_LPI;
               req_d   = 1'b1;
               hold_d  = 1'b1;
            end
            else if (us_tick_q && part_q)
               part_d = 1'b0;   // only whole microseconds of empty time count
            else if (us_tick_q)
               timer_d = sat_inc(timer_q);
         end
         TX_LPI:
         begin
            if (!tx_fifo_empty || !allow_w)
               state_d = TX_DRAIN;
            else
               req_d = 1'b1;
         end
         TX_DRAIN:
         begin
            // the wake wait starts only once the phy side has really left lpi
            timer_d = '0;
            part_d  = 1'b1;
            if (!phy_lpi_s)
               state_d = TX_TWAIT;
         end
         TX_TWAIT:
         begin
            ipg_d = '0;
            if (wake_met_w)
               state_d = TX_IPG;
            else if (us_tick_q && part_q)
               part_d = 1'b0;   // a partial first us would cut the wake wait short
            else if (us_tick_q)
               timer_d = sat_inc(timer_q);
         end
         TX_IPG:
         begin
            if (ipg_met_w)
            begin
               state_d = TX_IDLE;
               hold_d  = 1'b0;
            end
            else
               ipg_d = ipg_q + 1'b1;
         end
         default:
         begin
            state_d = TX_IDLE;
            hold_d  = 1'b0;
         end
      endcase
   end

   // state registers; the empty timer is forced to zero while disabled
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_q <= TX_IDLE;
         timer_q <= '0;
         ipg_q   <= '0;
         req_q   <= 1'b0;
         hold_q  <= 1'b0;
         part_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         timer_q <= timer_d;
         ipg_q   <= ipg_d;
         req_q   <= req_d;
         hold_q  <= hold_d;
         part_q  <= part_d;
      end
   end

   // ---------------- link domain reset
   // reset is brought over as a level; it only acts while phy_clk runs
   eeelpc_sync #(
      .W (1)
   ) u_rst_sync (
      .clk (phy_clk),
      .d   (sys_rst),
      .q   (link_rst)
   );

   // ---------------- request into the link domain
   eeelpc_sync #(
      .W (1)
   ) u_req_sync (
      .clk (phy_clk),
      .d   (req_q),
      .q   (req_s)
   );

   // lpi is entered only between frames, and left as soon as the request drops
   wire phy_lpi_d = req_s && (phy_lpi_q || !mac_txen);

   always_ff @(posedge phy_clk)
   begin
      if (link_rst)
      begin
         phy_lpi_q <= 1'b0;
         txen_q    <= 1'b0;
         txer_q    <= 1'b0;
         txd_q     <= '0;
      end
      else
      begin
         phy_lpi_q <= phy_lpi_d;
         txen_q    <= phy_lpi_d ? 1'b0 : mac_txen;
         txer_q    <= phy_lpi_d ? 1'b1 : mac_txer;
         txd_q     <= phy_lpi_d ? LPI_CODE : mac_txd;
      end
   end

   // ---------------- receive lpi decode at the pins
   // the mii inputs are synchronous to phy_clk, so one register suffices
   wire rx_code_w = !mii_rxdv && mii_rxer && (mii_rxd == LPI_CODE);

   always_ff @(posedge phy_clk)
   begin
      if (link_rst)
         rx_code_q <= 1'b0;
      else
         rx_code_q <= rx_code_w;
   end

   // ---------------- link levels back to the core
   eeelpc_sync #(
      .W (2)
   ) u_back_sync (
      .clk (ref_clk),
      .d   ({phy_lpi_q, rx_code_q}),
      .q   ({phy_lpi_s, rx_lpi_s})
   );

   // receive decode is gated by the same allowance as transmit
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         rx_active_q <= 1'b0;
      else
         rx_active_q <= rx_lpi_s && allow_w;
   end

   // ---------------- statistics
   // tx time follows the phy-side request, so the wake wait is not counted
   eeelpc_lpi_cnt u_tx_cnt (
      .clk         (ref_clk),
      .rst         (sys_rst),
      .enable      (energy_saving_enable),
      .active      (phy_lpi_s),
      .us_tick     (us_tick_q),
      .trans_cnt_q (tx_lpi_transitions),
      .time_cnt_q  (tx_lpi_time_us)
   );

   eeelpc_lpi_cnt u_rx_cnt (
      .clk         (ref_clk),
      .rst         (sys_rst),
      .enable      (energy_saving_enable),
      .active      (rx_active_q),
      .us_tick     (us_tick_q),
      .trans_cnt_q (rx_lpi_transitions),
      .time_cnt_q  (rx_lpi_time_us)
   );

   // ---------------- outputs, all from flip-flops
   assign mii_txen       = txen_q;
   assign mii_txer       = txer_q;
   assign mii_txd        = txd_q;
   assign tx_lpi_request = req_q;
   assign tx_hold_off    = hold_q;
   assign rx_lpi_active  = rx_active_q;
   assign link_stable    = link_stable_q;

endmodule

// >>> eeelpc_checker.sv
// assertion checker for the low-power-idle control block
`timescale 1ns/100ps
module eeelpc_checker
   import eeelpc_pkg::*;
(
   input wire logic             ref_clk,               // core clock
   input wire logic             sys_rst,               // core reset
   input wire logic             phy_clk,               // link clock
   input wire logic             energy_saving_enable,  // master enable
   input wire logic             tx_fifo_empty,         // fifo empty
   input wire logic             mac_txen,              // mac enable
   input wire logic             mii_txen,              // phy enable
   input wire logic             mii_txer,              // phy error
   input wire logic [NIB_W-1:0] mii_txd,               // phy nibble
   input wire logic             tx_lpi_request,        // client request
   input wire logic             tx_hold_off,           // frame hold
   input wire logic             rx_lpi_active,         // rx lpi
   input wire logic             link_stable,           // link aged
   input wire logic [CNT_W-1:0] tx_lpi_transitions,    // tx count
   input wire logic [CNT_W-1:0] tx_lpi_time_us,        // tx time
   input wire logic [CNT_W-1:0] rx_lpi_transitions,    // rx count
   input wire logic [CNT_W-1:0] rx_lpi_time_us         // rx time
);
   // lpi pattern on the transmit pins, seen from the core clock
   wire tx_lpi_code = !mii_txen && mii_txer && (mii_txd == LPI_CODE);

   // request, rx decode and counter gating, request withdrawal; two clocks here, so every property names its own
   a_req_needs_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !energy_saving_enable |=> !tx_lpi_request)
      else $error("tx request while disabled");
   a_req_after_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !link_stable |=> !tx_lpi_request)
      else $error("tx request before link aged");
   a_req_withdrawn: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !tx_fifo_empty |=> !tx_lpi_request)
      else $error("tx request kept with data queued");
   a_rx_needs_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !energy_saving_enable |=> !rx_lpi_active)
      else $error("rx lpi decoded while disabled");
   a_counters_cleared: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !energy_saving_enable |=>
      (tx_lpi_transitions | tx_lpi_time_us | rx_lpi_transitions | rx_lpi_time_us) == '0)
      else $error("lpi counter not zero while disabled");
   // the pattern may only appear while frames are held back
   a_code_held_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      tx_lpi_code |-> tx_hold_off)
      else $error("lpi pattern without hold off");
   a_hold_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(tx_lpi_request) |=> tx_hold_off [*8])
      else $error("hold off dropped before wake wait");
   a_frame_kept: assert property (@(posedge phy_clk) disable iff (sys_rst)
      mac_txen |=> mii_txen)
      else $error("frame cut on the mii");
   // counters move by at most one step per cycle
   a_tx_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
      energy_saving_enable && $past(energy_saving_enable) |->
      (tx_lpi_transitions - $past(tx_lpi_transitions)) <= 32'h1)
      else $error("tx transition count jumped");
   a_tx_time_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
      energy_saving_enable && $past(energy_saving_enable) |->
      (tx_lpi_time_us - $past(tx_lpi_time_us)) <= 32'h1)
      else $error("tx time count jumped");
   a_rx_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
      energy_saving_enable && $past(energy_saving_enable) |->
      (rx_lpi_transitions - $past(rx_lpi_transitions)) <= 32'h1 &&
      (rx_lpi_time_us - $past(rx_lpi_time_us)) <= 32'h1)
      else $error("rx lpi count jumped");
   // main scenarios reached
   c_tx_request: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(tx_lpi_request));
   c_rx_lpi: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(rx_lpi_active));
   c_code_seen: cover property (@(posedge ref_clk) disable iff (sys_rst) tx_lpi_code);
endmodule

bind eeelpc_top eeelpc_checker u_chk (.ref_clk, .sys_rst, .phy_clk, .energy_saving_enable, .tx_fifo_empty,
   .mac_txen, .mii_txen, .mii_txer, .mii_txd, .tx_lpi_request, .tx_hold_off, .rx_lpi_active, .link_stable,
   .tx_lpi_transitions, .tx_lpi_time_us, .rx_lpi_transitions, .rx_lpi_time_us);

// >>> eeelpc_phy_model.sv
// mii phy model: sends receive lpi on command, watches transmit lpi
`timescale 1ns/100ps
module eeelpc_phy_model
   import eeelpc_pkg::*;
(
   input  wire logic             phy_clk,             // link clock
   input  wire logic             rx_lpi_cmd,          // send rx lpi
   input  wire logic             mii_txen,            // from mac
   input  wire logic             mii_txer,            // from mac
   input  wire logic [NIB_W-1:0] mii_txd,             // from mac
   output logic                  mii_rxdv = 1'b0,     // to mac
   output logic                  mii_rxer = 1'b0,     // to mac
   output logic      [NIB_W-1:0] mii_rxd = 4'h0,      // to mac
   output logic                  tx_lpi_seen = 1'b0   // mac asks lpi
);
   logic [NIB_W-1:0] idle_q = 4'h0;
   // idle nibbles walk each cycle so a stale value never looks like data
   always @(posedge phy_clk)
   begin
      idle_q <= idle_q + 4'h3;
      mii_rxdv <= 1'b0;
      mii_rxer <= rx_lpi_cmd;
      mii_rxd <= rx_lpi_cmd ? LPI_CODE : idle_q;
      tx_lpi_seen <= !mii_txen && mii_txer && (mii_txd == LPI_CODE);
   end
endmodule

// >>> eeelpc_top_tb.sv
// self-checking testbench for the low-power-idle control block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module eeelpc_top_tb;
   import eeelpc_pkg::*;
   localparam int US = CYCLES_PER_US;
   int num_errors = 0;
   int checks_done = 0;
   logic ref_clk = 1'b0, phy_clk = 1'b0, sys_rst = 1'b1;
   logic energy_saving_enable = 1'b1, speed_100 = 1'b1, full_duplex = 1'b1;
   logic eee_local_adv = 1'b1, eee_partner_adv = 1'b1, phy_link_up = 1'b0;
   logic tx_fifo_empty = 1'b1, tx_frame_active = 1'b0, rx_lpi_cmd = 1'b0;
   logic [DELAY_W-1:0] tx_lpi_request_delay = 16'h0000, tx_wake_wait_time = 16'h0003;
   logic mac_txen = 1'b0, mac_txer = 1'b0;
   logic [NIB_W-1:0] mac_txd = 4'h0, mii_rxd, mii_txd;
   logic mii_rxdv, mii_rxer, mii_txen, mii_txer, tx_lpi_seen;
   logic tx_lpi_request, tx_hold_off, rx_lpi_active, link_stable;
   logic [CNT_W-1:0] tx_lpi_transitions, tx_lpi_time_us, rx_lpi_transitions, rx_lpi_time_us;

   // core clock and an unrelated link clock
   always #5 ref_clk = ~ref_clk;
   initial #3 forever #62.5 phy_clk = ~phy_clk;

   // link age shortened to 20 us to keep the run short
   eeelpc_top #(.LINK_STABLE(20)) dut (.*);
   eeelpc_phy_model u_phy (.*);

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // bounded wait for a level, then compare it
   task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim)
      begin
         cyc(1);
         n++;
      end
      `CHK("wait level", v, s)
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // main sequence; reset held 20 core cycles, the link side's synced reset trails it
   initial
   begin
      int n;
      logic [CNT_W-1:0] t;
      cyc(19);
      @(posedge ref_clk) sys_rst <= 1'b0;
      cyc(1);
      `CHK("tx count at reset", 32'h0, tx_lpi_transitions)
      // delay is zero, so only the link age holds the request back
      @(posedge ref_clk) phy_link_up <= 1'b1;
      cyc(10 * US);
      `CHK("request before link age", 1'b0, tx_lpi_request)
      wait_lvl(link_stable, 1'b1, 20 * US, n);
      cyc(3);
      `CHK("request at zero delay", 1'b1, tx_lpi_request)
      wait_lvl(tx_lpi_seen, 1'b1, 100, n);
      `CHK("mii txd lpi", LPI_CODE, mii_txd)
      cyc(5 * US);
      `CHK("tx transitions", 32'h1, tx_lpi_transitions)
      t = tx_lpi_time_us;
      `CHK("tx time range", 1'b1, t >= 32'h4 && t <= 32'h6)
      // data arrives: withdraw, then wake wait plus gap
      @(posedge ref_clk) tx_fifo_empty <= 1'b0;
      cyc(2);
      `CHK("request withdrawn", 1'b0, tx_lpi_request)
      wait_lvl(tx_hold_off, 1'b0, 10 * US, n);
      `CHK("wake wait span", 1'b1, n >= 3 * US + IPG_CYCLES && n <= 5 * US + IPG_CYCLES)
      // a short burst of data restarts the empty time
      @(posedge ref_clk) tx_lpi_request_delay <= 16'h0005;
      tx_fifo_empty <= 1'b1;
      cyc(3 * US);
      @(posedge ref_clk) tx_fifo_empty <= 1'b0;
      @(posedge ref_clk) tx_fifo_empty <= 1'b1;
      cyc(350);
      `CHK("empty time restarted", 1'b0, tx_lpi_request)
      // a frame on the mii when the request comes must finish first
      @(posedge phy_clk) mac_txen <= 1'b1;
      mac_txd <= 4'hA;
      wait_lvl(tx_lpi_request, 1'b1, 3 * US, n);
      cyc(US);
      `CHK("frame kept on mii", 4'hA, mii_txd)
      `CHK("frame txen kept", 1'b1, mii_txen)
      @(posedge phy_clk) mac_txen <= 1'b0;
      wait_lvl(tx_lpi_seen, 1'b1, 100, n);
      `CHK("second transition", 32'h2, tx_lpi_transitions)
      // speed change takes the allowance away in both directions
      @(posedge ref_clk) speed_100 <= 1'b0;
      cyc(3);
      `CHK("request off at 10 Mbps", 1'b0, tx_lpi_request)
      @(posedge phy_clk) rx_lpi_cmd <= 1'b1;
      cyc(3 * US);
      `CHK("rx lpi ignored", 1'b0, rx_lpi_active)
      `CHK("rx count idle", 32'h0, rx_lpi_transitions)
      @(posedge ref_clk) speed_100 <= 1'b1;
      wait_lvl(rx_lpi_active, 1'b1, 20, n);
      cyc(5 * US);
      @(posedge phy_clk) rx_lpi_cmd <= 1'b0;
      wait_lvl(rx_lpi_active, 1'b0, 100, n);
      `CHK("rx transitions", 32'h1, rx_lpi_transitions)
      t = rx_lpi_time_us;
      `CHK("rx time range", 1'b1, t >= 32'h4 && t <= 32'h7)
      // fifo data ends any request, then the empty timer runs short of its delay
      @(posedge ref_clk) tx_fifo_empty <= 1'b0;
      wait_lvl(tx_hold_off, 1'b0, 10 * US, n);
      @(posedge ref_clk) tx_fifo_empty <= 1'b1;
      cyc(3 * US);
      // disabling clears all counters and clears the empty timer
      @(posedge ref_clk) energy_saving_enable <= 1'b0;
      cyc(2);
      `CHK("tx count cleared", 32'h0, tx_lpi_transitions)
      `CHK("rx time cleared", 32'h0, rx_lpi_time_us)
      cyc(2 * US);
      `CHK("no request while disabled", 1'b0, tx_lpi_request)
      @(posedge ref_clk) energy_saving_enable <= 1'b1;
      // a kept timer would reach the delay here, a cleared one needs over 5 us
      cyc(4 * US);
      `CHK("empty timer held off", 1'b0, tx_lpi_request)
      print_verdict;
   end

   // the sequence needs about 6000 cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      print_verdict;
   end
endmodule
